// ==== logic/clock_divider_pkg.sv ====
// Summary of operation
// - prescaler divides by ratio field plus one
// - prescaler ratio resets to zero, divide by one
// - post-divider one drives system clock one, both paths
// - post-divider one enable bit 15, resets set
// - post-divider one ratio decodes 1,2,4; resets 00011
// - bits 14 to 5 read zero, ignore writes
// - post-divider two drives system clock two, both paths
// - post-divider two enable bit 15, resets set
// - post-divider two ratio decodes 1,2,4; resets 00011
// - post-divider three drives system clock three, both paths
// - post-divider three enable bit 15, resets set
// - post-divider three ratio decodes 1,2,4; resets 00011
// - oscillator divider fed from oscillator, never PLL
// - path select chooses reference or PLL source
// - prescaler enable bit 15, resets set
// - oscillator divider divides by ratio plus one
// - oscillator divider enable bit 15, resets clear
package clock_divider_pkg;

  localparam int RATIO_W   = 5;
  localparam int NUM_DIV   = 5;
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 32;

  // divider slots, also register slots
  localparam logic [2:0] SLOT_PRESCALER = 3'h0;
  localparam logic [2:0] SLOT_POST_ONE  = 3'h1;
  localparam logic [2:0] SLOT_POST_TWO  = 3'h2;
  localparam logic [2:0] SLOT_POST_THR  = 3'h3;
  localparam logic [2:0] SLOT_OSC       = 3'h4;
  localparam logic [2:0] SLOT_CONTROL   = 3'h5;
  localparam logic [2:0] SLOT_NONE      = 3'h7;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_PRESCALER_DIVIDER  = 16'h1C8A;
  localparam logic [ADDR_W-1:0] IDX_SYSCLK_ONE_DIVIDER = 16'h1C8C;
  localparam logic [ADDR_W-1:0] IDX_SYSCLK_TWO_DIVIDER = 16'h1C8E;
  localparam logic [ADDR_W-1:0] IDX_SYSCLK_THR_DIVIDER = 16'h1C90;
  localparam logic [ADDR_W-1:0] IDX_OSC_OUT_DIVIDER    = 16'h1C92;
  localparam logic [ADDR_W-1:0] IDX_PATH_CONTROL       = 16'h1CA0;
  localparam int               IDX_SHIFT              = 2;

  localparam int ENABLE_BIT    = 15;
  localparam int PATH_SEL_BIT  = 0;
  localparam int PLL_LEVEL_BIT = 1;

  // enable reset per slot: prescaler, three post-dividers set, osc clear
  localparam logic [NUM_DIV-1:0] ENABLE_RESET   = 5'h0F;
  localparam logic [RATIO_W-1:0] PRESCALE_RESET = 5'h00;
  localparam logic [RATIO_W-1:0] POST_RESET     = 5'h03;
  localparam logic [RATIO_W-1:0] OSC_RESET      = 5'h00;

  localparam logic [RATIO_W-1:0] POST_DIV1 = 5'h00;
  localparam logic [RATIO_W-1:0] POST_DIV2 = 5'h01;
  localparam logic [RATIO_W-1:0] POST_DIV4 = 5'h03;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== logic/clock_divider_set.sv ====
`timescale 1ns/1ps
module clock_divider_set
  import clock_divider_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pll_clk_in,
  output logic                   prescaler_tick,
  output logic                   system_clock_one,
  output logic                   system_clock_two,
  output logic                   system_clock_three,
  output logic                   third_clock_output
);

  function automatic logic [2:0] reg_slot(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] idx;
    idx = addr >> IDX_SHIFT;
    if (addr[IDX_SHIFT-1:0] != '0) begin
      reg_slot = SLOT_NONE;
    end else begin
      case (idx)
        IDX_PRESCALER_DIVIDER:  reg_slot = SLOT_PRESCALER;
        IDX_SYSCLK_ONE_DIVIDER: reg_slot = SLOT_POST_ONE;
        IDX_SYSCLK_TWO_DIVIDER: reg_slot = SLOT_POST_TWO;
        IDX_SYSCLK_THR_DIVIDER: reg_slot = SLOT_POST_THR;
        IDX_OSC_OUT_DIVIDER:    reg_slot = SLOT_OSC;
        IDX_PATH_CONTROL:       reg_slot = SLOT_CONTROL;
        default:                reg_slot = SLOT_NONE;
      endcase
    end
  endfunction

  // post-divider codes to terminal count; reserved codes fall back to divide by 4
  function automatic logic [RATIO_W-1:0] post_terminal(input logic [RATIO_W-1:0] code);
    case (code)
      POST_DIV1: post_terminal = POST_DIV1;
      POST_DIV2: post_terminal = POST_DIV2;
      POST_DIV4: post_terminal = POST_DIV4;
      default:   post_terminal = POST_DIV4;
    endcase
  endfunction

  logic [NUM_DIV-1:0] enable_reg;
  logic [RATIO_W-1:0] ratio_reg [NUM_DIV];
  logic               path_select_reg;
  logic               pll_meta_reg;
  logic               pll_sync_reg;
  logic               pll_prev_reg;
  logic               pll_tick;
  logic               post_src_tick;
  logic [NUM_DIV-1:0] div_tick;
  logic [ADDR_W-1:0]  awaddr_reg;
  logic [DATA_W-1:0]  wdata_reg;
  logic [3:0]         wstrb_reg;
  logic               do_write;
  logic [2:0]         wr_slot;
  logic [2:0]         rd_slot;

  // pll output arrives from another clock tree: two stages before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_meta_reg <= 1'b0;
      pll_sync_reg <= 1'b0;
      pll_prev_reg <= 1'b0;
    end else begin
      pll_meta_reg <= pll_clk_in;
      pll_sync_reg <= pll_meta_reg;
      pll_prev_reg <= pll_sync_reg;
    end
  end

  assign pll_tick = pll_sync_reg && !pll_prev_reg;
  // reference clock is aclk itself, so every cycle is a reference tick
  assign post_src_tick = path_select_reg ? pll_tick : 1'b1;

  // write channel: address and data accepted independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      awaddr_reg    <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_reg    <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_slot  = reg_slot(awaddr_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_slot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only bit 15 and the ratio field are stored; the rest never holds state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg                  <= ENABLE_RESET;
      ratio_reg[SLOT_PRESCALER]   <= PRESCALE_RESET;
      ratio_reg[SLOT_POST_ONE]    <= POST_RESET;
      ratio_reg[SLOT_POST_TWO]    <= POST_RESET;
      ratio_reg[SLOT_POST_THR]    <= POST_RESET;
      ratio_reg[SLOT_OSC]         <= OSC_RESET;
    end else if (do_write && wr_slot < SLOT_CONTROL) begin
      if (wstrb_reg[1]) begin
        enable_reg[wr_slot] <= wdata_reg[ENABLE_BIT];
      end
      if (wstrb_reg[0]) begin
        ratio_reg[wr_slot] <= wdata_reg[RATIO_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      path_select_reg <= 1'b0;
    end else if (do_write && wr_slot == SLOT_CONTROL && wstrb_reg[0]) begin
      path_select_reg <= wdata_reg[PATH_SEL_BIT];
    end
  end

  // read channel: one outstanding read, answered the cycle after acceptance
  assign rd_slot = reg_slot(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
      if (rd_slot < SLOT_CONTROL) begin
        s_axi_rdata[ENABLE_BIT]    <= enable_reg[rd_slot];
        s_axi_rdata[RATIO_W-1:0]   <= ratio_reg[rd_slot];
      end else if (rd_slot == SLOT_CONTROL) begin
        s_axi_rdata[PATH_SEL_BIT]  <= path_select_reg;
        s_axi_rdata[PLL_LEVEL_BIT] <= pll_sync_reg;
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // slot 0 prescaler and slot 4 oscillator divider run on the reference;
  // slots 1 to 3 follow the path select and use the restricted decode
  generate
    for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
      if (i == SLOT_PRESCALER || i == SLOT_OSC) begin : g_ref
        tick_divider #(.WIDTH(RATIO_W)) u_div (
          .aclk     (aclk),
          .aresetn  (aresetn),
          .src_tick (1'b1),
          .enable   (enable_reg[i]),
          .terminal (ratio_reg[i]),
          .tick_out (div_tick[i])
        );
      end else begin : g_post
        tick_divider #(.WIDTH(RATIO_W)) u_div (
          .aclk     (aclk),
          .aresetn  (aresetn),
          .src_tick (post_src_tick),
          .enable   (enable_reg[i]),
          .terminal (post_terminal(ratio_reg[i])),
          .tick_out (div_tick[i])
        );
      end
    end
  endgenerate

  assign prescaler_tick     = div_tick[SLOT_PRESCALER];
  assign system_clock_one   = div_tick[SLOT_POST_ONE];
  assign system_clock_two   = div_tick[SLOT_POST_TWO];
  assign system_clock_three = div_tick[SLOT_POST_THR];
  assign third_clock_output = div_tick[SLOT_OSC];

endmodule

// ==== logic/tick_divider.sv ====
`timescale 1ns/1ps
module tick_divider
  import clock_divider_pkg::*;
#(
  parameter int WIDTH = RATIO_W
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             src_tick,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] terminal,
  output logic                  tick_out
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] active_reg;

  // terminal is divisor minus one; out pulses once per divisor source ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg  <= '0;
      active_reg <= '0;
    end else if (!enable) begin
      count_reg  <= '0;
      active_reg <= terminal;
    end else if (src_tick) begin
      if (count_reg >= active_reg) begin
        count_reg  <= '0;
        active_reg <= terminal;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= enable && src_tick && (count_reg >= active_reg);
    end
  end

endmodule

// ==== verification/clock_divider_set_sva.sv ====
`timescale 1ns/1ps
module clock_divider_set_sva
  import clock_divider_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              system_clock_two,
  input wire logic              third_clock_output
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready) |=> !s_axi_awready ##1 s_axi_bvalid) else $error("late write answer");
  a_read_answer: assert property ((s_axi_arvalid && s_axi_arready)
    |=> s_axi_rvalid && !s_axi_arready) else $error("late read answer");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not closed");
  a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read not closed");
  a_reserved_bits_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[14:5] == 10'h000 && s_axi_rdata[31:16] == 16'h0000) else $error("reserved set");
  // earliest write lands at the second edge after release; no pulse shows before the fourth
  a_osc_idle_reset: assert property ($rose(aresetn) |-> !third_clock_output [*3])
    else $error("osc divider active after reset");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_read_ok: cover property (s_axi_rvalid && s_axi_rresp == RESP_OKAY);
  c_osc_pulse: cover property (third_clock_output ##1 !third_clock_output);
  c_sys_two: cover property (system_clock_two);
endmodule
bind clock_divider_set clock_divider_set_sva i_clock_divider_set_sva (.*);

// ==== verification/clock_divider_set_tb.sv ====
`timescale 1ns/1ps
module clock_divider_set_tb
  import clock_divider_pkg::*;
;
  logic aclk = 0, aresetn = 0, pll_clk_in = 0, pll_run = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [DATA_W-1:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 0;
  logic [3:0]        strb = 4'hF;
  logic [2:0]        s_axi_awprot = 0, s_axi_arprot = 0;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, prescaler_tick, system_clock_one, system_clock_two;
  logic system_clock_three, third_clock_output;
  logic [4:0] tk;
  logic [4:0] code [3] = '{5'h00, 5'h01, 5'h03};
  logic [4:0] pr [4]   = '{5'h00, 5'h01, 5'h04, 5'h1F};
  int dv [3] = '{1, 2, 4};
  int bad_count = 0, samples_checked = 0, pc = 0, i, j;
  assign tk = {third_clock_output, system_clock_three, system_clock_two, system_clock_one,
               prescaler_tick};
  clock_divider_set i_clock_divider_set (.*);
  always #25 aclk = ~aclk;
  // pll stand-in: ten reference cycles a period, still until path tests begin
  always @(posedge aclk) begin
    pc <= (pc == 4) ? 0 : pc + 1;
    if (pc == 4 && pll_run) pll_clk_in <= ~pll_clk_in;
  end
  function automatic logic [ADDR_W-1:0] ba(input int k);
    return (IDX_PRESCALER_DIVIDER + 16'(2 * k)) << IDX_SHIFT;
  endfunction
  task complete_run;
    $display("checks=%0d errors=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task to_fail;
    bad_count++;
    complete_run();
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) to_fail();
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) to_fail();
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // skip pulses so a ratio change has landed, then time one full period
  task per(input int k, input int exp);
    int n, c;
    c = 0;
    for (n = 0; n < 400 && c < 3; n++) begin
      @(posedge aclk);
      if (tk[k] === 1'b1) c++;
    end
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (tk[k] === 1'b1) break;
    end
    if (n == 400) to_fail();
    check(32'(n + 1), 32'(exp));
  endtask
  task quiet(input int k);
    logic s;
    s = 1'b0;
    repeat (40) begin
      @(posedge aclk);
      s = s | tk[k];
    end
    check({31'h0, s}, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ba(0), 32'h8000, RESP_OKAY);
    for (i = 1; i < 4; i++) rd(ba(i), 32'h8003, RESP_OKAY);
    rd(ba(4), 32'h0, RESP_OKAY);
    rd(IDX_PATH_CONTROL << IDX_SHIFT, 32'h0, RESP_OKAY);
    per(0, 1);
    for (i = 1; i < 4; i++) per(i, 4);
    quiet(4);
    rd(16'h0000, 32'h0, RESP_SLVERR);
    rd(ba(1) + 16'h1, 32'h0, RESP_SLVERR);
    wr(16'h0004, 32'h8001, RESP_SLVERR);
    wr(ba(1), 32'h7FE1, RESP_OKAY);
    rd(ba(1), 32'h0001, RESP_OKAY);
    quiet(1);
    // low lane only: ratio lands, enable bit must survive
    strb = 4'h1;
    wr(ba(2), 32'h0000, RESP_OKAY);
    strb = 4'hF;
    rd(ba(2), 32'h8000, RESP_OKAY);
    for (i = 1; i < 4; i++)
      for (j = 0; j < 3; j++) begin
        wr(ba(i), 32'h8000 | 32'(code[j]), RESP_OKAY);
        per(i, dv[j]);
      end
    for (i = 0; i < 5; i += 4)
      for (j = 0; j < 4; j++) begin
        wr(ba(i), 32'h8000 | 32'(pr[j]), RESP_OKAY);
        per(i, 32'(pr[j]) + 1);
      end
    wr(ba(0), 32'h0, RESP_OKAY);
    quiet(0);
    pll_run <= 1'b1;
    wr(IDX_PATH_CONTROL << IDX_SHIFT, 32'h1, RESP_OKAY);
    wr(ba(1), 32'h8000, RESP_OKAY);
    per(1, 10);
    per(3, 40);
    per(4, 32);
    complete_run();
  end
endmodule
